// ===== hdl/sdram_cmd_pkg.sv
// Shared constants and types for the SDRAM module command link.
package sdram_cmd_pkg;
	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 13;
	localparam int BANK_W       = 2;
	localparam int COL_W        = 11;
	// Mode register field positions, plus the auto precharge address bit.
	localparam int BL_LSB       = 0;
	localparam int ORDER_BIT    = 3;
	localparam int LAT_LSB      = 4;
	localparam int OPM_LSB      = 7;
	localparam int SINGLE_WR    = 9;
	localparam int AUTO_PRE_BIT = 10;
	// Burst length and latency encodings.
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [2:0] LAT_2   = 3'h2;
	localparam logic [2:0] LAT_3   = 3'h3;
	localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0022;
	// Extra cycle added by the input register in registered mode.
	localparam int REG_EXTRA    = 1;
	// Read mask acts two clocks late.
	localparam int MASK_RD_LAG  = 2;
	// Host register offsets (byte addresses).
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_DATA   = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	// Command codes as cs,ras,cas,we.
	typedef enum logic [3:0] {
		CMD_NOP   = 4'h7,
		CMD_ACT   = 4'h3,
		CMD_READ  = 4'h5,
		CMD_WRITE = 4'h4,
		CMD_TERM  = 4'h6,
		CMD_PRE   = 4'h2,
		CMD_REF   = 4'h1,
		CMD_LMR   = 4'h0,
		CMD_INH   = 4'h8
	} cmd_t;
endpackage

// ===== hdl/sdram_host_ctrl.sv
// Host end: Avalon-MM register slave that issues one link command per order.
`timescale 1ns/10ps
module sdram_host_ctrl (
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic [3:0]          avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	output logic [31:0]              avs_readdata,
	output logic                     avs_waitrequest,
	sdram_link_if.host               link
);
	typedef struct packed {
		logic [3:0]                       cmd;
		logic                             cke;
		logic [1:0]                       bank;
		logic [12:0]                      addr;
		logic                             mask;
		logic [7:0]                       wdata;
		logic                             drive_n;
		logic [7:0]                       rdata;
		logic [31:0]                      rd;
		logic                             ack;
		logic                             busy;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic   illegal;

	// Accept register writes; command word issues for one cycle.
	always_comb begin
		s_d     = s_q;
		s_d.cmd = sdram_cmd_pkg::CMD_NOP;
		s_d.ack = 1'b0;
		s_d.rdata = link.dq;
		illegal = 1'b0;
		if ((avs_read || avs_write) && !s_q.ack) begin
			s_d.ack = 1'b1;
			s_d.rd  = 32'h0000_0000;
			if (avs_write) begin
				case (avs_address)
					sdram_cmd_pkg::REG_CMD: begin
						// Refuse reserved mode loads and interleaved full page.
						if (avs_writedata[3:0] == sdram_cmd_pkg::CMD_LMR)
							illegal = s_q.addr[8:7] != 2'h0
								|| (s_q.addr[2:0] == sdram_cmd_pkg::BL_FULL
								&& s_q.addr[3])
								|| (s_q.addr[6:4] != sdram_cmd_pkg::LAT_2
								&& s_q.addr[6:4] != sdram_cmd_pkg::LAT_3);
						if (!illegal)
							s_d.cmd = avs_writedata[3:0];
						// Clock enable low only for self refresh entry.
						s_d.cke = !(avs_writedata[3:0] == sdram_cmd_pkg::CMD_REF
							&& avs_writedata[4]);
						s_d.mask = avs_writedata[5];
					end
					sdram_cmd_pkg::REG_ADDR: begin
						s_d.addr = avs_writedata[12:0];
						s_d.bank = avs_writedata[17:16];
					end
					sdram_cmd_pkg::REG_DATA: begin
						s_d.wdata   = avs_writedata[7:0];
						s_d.drive_n = avs_writedata[8];
					end
					default: ;
				endcase
			end else begin
				case (avs_address)
					sdram_cmd_pkg::REG_ADDR:
						s_d.rd = {14'h0, s_q.bank, 3'h0, s_q.addr};
					sdram_cmd_pkg::REG_DATA:
						s_d.rd = {23'h0, s_q.drive_n, s_q.wdata};
					sdram_cmd_pkg::REG_STATUS:
						s_d.rd = {23'h0, s_q.cke, s_q.rdata};
					default: s_d.rd = 32'h0000_0000;
				endcase
			end
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q         <= '0;
			s_q.cmd     <= sdram_cmd_pkg::CMD_NOP;
			s_q.cke     <= 1'b1;
			s_q.drive_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.cs_n           = 1'b0;
	assign link.ras_n          = s_q.cmd[2];
	assign link.cas_n          = s_q.cmd[1];
	assign link.we_n           = s_q.cmd[0];
	assign link.cke            = s_q.cke;
	assign link.bank           = s_q.bank;
	assign link.addr           = s_q.addr;
	assign link.byte_data_mask = s_q.mask;
	assign link.dq_host_o      = s_q.wdata;
	assign link.dq_host_oe_n   = s_q.drive_n;
	assign avs_readdata        = s_q.rd;
	assign avs_waitrequest     = !s_q.ack;
endmodule

// ===== hdl/sdram_link_if.sv
// Interface joining the host controller and the SDRAM module model.
`timescale 1ns/10ps
interface sdram_link_if;
	logic                                cs_n;
	logic                                ras_n;
	logic                                cas_n;
	logic                                we_n;
	logic                                cke;
	logic [sdram_cmd_pkg::BANK_W-1:0]    bank;
	logic [sdram_cmd_pkg::ADDR_W-1:0]    addr;
	logic                                byte_data_mask;
	logic [sdram_cmd_pkg::DATA_W-1:0]    dq_host_o;
	logic                                dq_host_oe_n;
	logic [sdram_cmd_pkg::DATA_W-1:0]    dq_dev_o;
	logic                                dq_dev_oe_n;
	logic [sdram_cmd_pkg::DATA_W-1:0]    dq;
	// Resolved data bus level.
	assign dq = !dq_dev_oe_n ? dq_dev_o :
		(!dq_host_oe_n ? dq_host_o : '0);
	modport host (output cs_n, ras_n, cas_n, we_n, cke, bank, addr,
		byte_data_mask, dq_host_o, dq_host_oe_n, input dq);
	modport dev (input cs_n, ras_n, cas_n, we_n, cke, bank, addr,
		byte_data_mask, input dq, output dq_dev_o, dq_dev_oe_n);
endinterface

// ===== hdl/sdram_module_dev.sv
// SDRAM module end: command decode, burst addressing and data timing.
//
// Contract
// - Length two pairs columns, toggles bit zero.
// - Length four sequential increments, interleaved XORs.
// - Length eight sequential increments, interleaved XORs.
// - Full page sequential only, whole row.
// - Bursts wrap inside their selected block.
// - Length one accesses one column only.
// - Read drives one cycle before latency edge.
// - Host programs operating mode bits zero.
// - Single write bit makes writes one location.
// - Registered mode adds one latency cycle.
// - Host picks latency allowed at frequency.
// - Commands decode from four control lines.
// - Activate carries row and bank.
// - Read and write carry column and bank.
// - Address ten selects auto precharge per access.
// - Precharge address ten selects one or all.
// - Refresh auto or self by clock enable.
// - Host keeps clock enable high normally.
// - Mask zero-lag on writes, two on reads.
// - Load mode stores address lines as op-code.
// - Host never programs reserved mode encodings.
// - Mode fields length, order, latency, mode, write.
// - Latency only two or three.
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
module sdram_module_dev #(
	parameter int COLS  = 1024,
	parameter int DEPTH = 64
) (
	input  wire logic                     clk_i,
	input  wire logic                     reset_n_i,
	sdram_link_if.dev                     link,
	output logic [3:0]                    open_banks_o,
	output logic                          self_refresh_o,
	output logic                          auto_pre_o,
	output logic [7:0]                    refresh_count_o
);
	localparam int CW = sdram_cmd_pkg::COL_W;
	localparam int DW = sdram_cmd_pkg::DATA_W;
	localparam int AW = $clog2(DEPTH);

	// Refuse sizes that the column wrap and the word index cannot serve.
	if (COLS != 1024 && COLS != 2048) begin : g_cols_chk
		$error("COLS must be 1024 or 2048");
	end
	if (DEPTH < 8 || DEPTH > COLS || DEPTH != (1 << AW)) begin : g_depth
		$error("DEPTH must be a power of two from 8 to COLS");
	end

	typedef struct packed {
		logic [sdram_cmd_pkg::ADDR_W-1:0] mode;
		logic [3:0]                       open;
		logic                             self_ref;
		logic                             auto_pre;
		logic [7:0]                       ref_cnt;
		logic                             rd_act;
		logic                             wr_act;
		logic [CW-1:0]                    start;
		logic [CW-1:0]                    cnt;
		logic [CW:0]                      left;
		logic [4:0]                       rd_valid;
		logic [5*AW-1:0]                  rd_addr;
		logic [2:0]                       mask_pipe;
		logic [DW-1:0]                    dq_out;
		logic                             dq_oe_n;
		logic [DEPTH*DW-1:0]              mem;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Column for step cnt of a burst that began at start.
	function automatic logic [CW-1:0] burst_col(
		input logic [CW-1:0] start,
		input logic [CW-1:0] cnt,
		input logic [2:0]    bl,
		input logic          ilv,
		input int            cols
	);
		logic [CW-1:0] m;
		logic [CW-1:0] off;
		m = '0;
		case (bl)
			sdram_cmd_pkg::BL_2:    m = 11'h001;
			sdram_cmd_pkg::BL_4:    m = 11'h003;
			sdram_cmd_pkg::BL_8:    m = 11'h007;
			sdram_cmd_pkg::BL_FULL: m = CW'(cols - 1);
			default:                m = '0;
		endcase
		// Interleave ignored for full page and length one.
		if (ilv && bl != sdram_cmd_pkg::BL_FULL)
			off = (start ^ cnt) & m;
		else
			off = (start + cnt) & m;
		burst_col = (start & ~m) | off;
	endfunction

	// Number of words for a burst length code.
	function automatic logic [CW:0] burst_len(
		input logic [2:0] bl,
		input int         cols
	);
		case (bl)
			sdram_cmd_pkg::BL_2:    burst_len = 12'h002;
			sdram_cmd_pkg::BL_4:    burst_len = 12'h004;
			sdram_cmd_pkg::BL_8:    burst_len = 12'h008;
			sdram_cmd_pkg::BL_FULL: burst_len = (CW+1)'(cols);
			default:                burst_len = 12'h001;
		endcase
	endfunction

	logic [3:0]    cmd;
	logic [2:0]    bl;
	logic          ilv;
	logic [2:0]    lat;
	logic [CW-1:0] col;
	logic [CW-1:0] cur;
	logic [AW-1:0] idx;
	int            lag;

	// Decode and burst engine.
	always_comb begin
		s_d = s_q;
		cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
		if (link.cs_n)
			cmd = sdram_cmd_pkg::CMD_INH;
		bl  = s_q.mode[sdram_cmd_pkg::BL_LSB +: 3];
		ilv = s_q.mode[sdram_cmd_pkg::ORDER_BIT];
		lat = s_q.mode[sdram_cmd_pkg::LAT_LSB +: 3];
		// Column bits are A0-A9, plus A11 on the wide row.
		col = {link.addr[11], link.addr[9:0]};
		if (COLS == 1024)
			col[10] = 1'b0;
		cur = burst_col(s_q.start, s_q.cnt, bl, ilv, COLS);
		idx = cur[AW-1:0];
		// Only the two legal latencies are honoured; others act as three.
		lag = (lat == sdram_cmd_pkg::LAT_2 ? 2 : 3)
			+ sdram_cmd_pkg::REG_EXTRA;
		// Shift read pipeline; slot lag-3 launches the output register.
		s_d.rd_valid  = {s_q.rd_valid[3:0], 1'b0};
		s_d.rd_addr   = {s_q.rd_addr[4*AW-1:0], {AW{1'b0}}};
		s_d.mask_pipe = {s_q.mask_pipe[1:0], link.byte_data_mask};
		// Advance the active burst one word per clock.
		if (s_q.rd_act || s_q.wr_act) begin
			if (s_q.rd_act) begin
				s_d.rd_valid[0]     = 1'b1;
				s_d.rd_addr[AW-1:0] = idx;
			end
			if (s_q.wr_act && !link.byte_data_mask)
				s_d.mem[idx*DW +: DW] = link.dq;
			s_d.cnt  = s_q.cnt + 1'b1;
			s_d.left = s_q.left - 1'b1;
			if (s_q.left == 12'h001) begin
				s_d.rd_act = 1'b0;
				s_d.wr_act = 1'b0;
			end
		end
		if (!link.cke && s_q.self_ref) begin
			cmd = sdram_cmd_pkg::CMD_INH;
		end else if (s_q.self_ref) begin
			s_d.self_ref = 1'b0;
		end
		case (cmd)
			sdram_cmd_pkg::CMD_ACT:
				s_d.open[link.bank] = 1'b1;
			sdram_cmd_pkg::CMD_READ, sdram_cmd_pkg::CMD_WRITE: begin
				s_d.start = col;
				s_d.cnt   = '0;
				s_d.auto_pre =
					link.addr[sdram_cmd_pkg::AUTO_PRE_BIT];
				s_d.rd_act = (cmd == sdram_cmd_pkg::CMD_READ);
				s_d.wr_act = (cmd == sdram_cmd_pkg::CMD_WRITE);
				if (cmd == sdram_cmd_pkg::CMD_WRITE &&
					s_q.mode[sdram_cmd_pkg::SINGLE_WR])
					s_d.left = 12'h001;
				else
					s_d.left = burst_len(bl, COLS);
			end
			sdram_cmd_pkg::CMD_TERM: begin
				s_d.rd_act = 1'b0;
				s_d.wr_act = 1'b0;
			end
			sdram_cmd_pkg::CMD_PRE:
				if (link.addr[sdram_cmd_pkg::AUTO_PRE_BIT])
					s_d.open = 4'h0;
				else
					s_d.open[link.bank] = 1'b0;
			sdram_cmd_pkg::CMD_REF:
				if (link.cke)
					s_d.ref_cnt = s_q.ref_cnt + 1'b1;
				else
					s_d.self_ref = 1'b1;
			sdram_cmd_pkg::CMD_LMR:
				s_d.mode = link.addr;
			default: ;
		endcase
		// Launch at the edge before the latency edge so data stand by it.
		// A mask seen two edges before the data edge keeps the word off.
		s_d.dq_oe_n = 1'b1;
		s_d.dq_out  = '0;
		if (s_q.rd_valid[lag-3] && !s_q.mask_pipe[0]) begin
			s_d.dq_oe_n = 1'b0;
			s_d.dq_out  =
				s_q.mem[s_q.rd_addr[(lag-3)*AW +: AW]*DW +: DW];
		end
	end

	// State register; memory contents clear at reset for determinism.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q          <= '0;
			s_q.mode     <= sdram_cmd_pkg::MODE_RESET;
			s_q.dq_oe_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.dq_dev_o    = s_q.dq_out;
	assign link.dq_dev_oe_n = s_q.dq_oe_n;
	assign open_banks_o     = s_q.open;
	assign self_refresh_o   = s_q.self_ref;
	assign auto_pre_o       = s_q.auto_pre;
	assign refresh_count_o  = s_q.ref_cnt;
endmodule

// ===== testbench/sdram_link_assertions.sv
// Concurrent checks on the link between host and module ends.
`timescale 1ns/10ps
module sdram_link_assertions (
	input wire logic                          clk_i,
	input wire logic                          reset_n_i,
	input wire logic                          cs_n,
	input wire logic                          ras_n,
	input wire logic                          cas_n,
	input wire logic                          we_n,
	input wire logic                          cke,
	input wire logic [sdram_cmd_pkg::ADDR_W-1:0] addr,
	input wire logic                          byte_data_mask,
	input wire logic                          dq_dev_oe_n
);
	logic is_rd;
	logic is_wr;
	logic is_lmr;
	logic is_ref;

	// Command decode from the four control lines.
	assign is_rd  = {cs_n, ras_n, cas_n, we_n} == sdram_cmd_pkg::CMD_READ;
	assign is_wr  = {cs_n, ras_n, cas_n, we_n} == sdram_cmd_pkg::CMD_WRITE;
	assign is_lmr = {cs_n, ras_n, cas_n, we_n} == sdram_cmd_pkg::CMD_LMR;
	assign is_ref = {cs_n, ras_n, cas_n, we_n} == sdram_cmd_pkg::CMD_REF;

	// One clock domain, so clock and reset are given once.
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_read_quiet: assert property (
		is_rd && dq_dev_oe_n |=> dq_dev_oe_n [*2])
		else $error("Read data driven too early.");
	a_read_drive: assert property (
		is_rd && !byte_data_mask |-> ##[3:4] !dq_dev_oe_n)
		else $error("Read data never driven.");
	a_mask_read: assert property (
		byte_data_mask |-> ##2 dq_dev_oe_n)
		else $error("Masked read word was driven.");
	a_write_quiet: assert property (
		is_wr |=> dq_dev_oe_n)
		else $error("Module drove data during a write.");
	a_cke_entry: assert property (
		$fell(cke) |-> is_ref)
		else $error("Clock enable dropped outside refresh.");
	a_mode_normal: assert property (
		is_lmr |-> addr[8:7] == 2'h0)
		else $error("Non-normal operating mode loaded.");
	a_mode_latency: assert property (
		is_lmr |-> addr[6:4] inside {3'h2, 3'h3})
		else $error("Reserved latency loaded.");
	a_page_order: assert property (
		is_lmr && addr[2:0] == 3'h7 |-> !addr[3])
		else $error("Interleaved full page loaded.");

	// Main scenarios reached.
	cover property (is_lmr);
	cover property (is_rd ##3 !dq_dev_oe_n);
	cover property ($fell(cke));
endmodule

// ===== testbench/sdram_module_command_burst_tb_top.sv
// Bench driving the host over Avalon and watching the link to the module.
`timescale 1ns/10ps
module sdram_module_command_burst_tb_top;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  open_banks;
	logic        self_refresh;
	logic        auto_pre;
	logic [7:0]  refresh_count;
	logic [31:0] rdv;
	logic [12:0] eff = sdram_cmd_pkg::MODE_RESET;
	logic [7:0]  q [$];
	logic [12:0] modes [9] = '{13'h021, 13'h02A, 13'h022, 13'h033,
		13'h02B, 13'h028, 13'h0AB, 13'h02F, 13'h012};
	logic [12:0] cols [9] = '{13'h001, 13'h001, 13'h006, 13'h003,
		13'h001, 13'h005, 13'h002, 13'h007, 13'h405};
	int          err_total = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          rd_cyc = 0;
	int          first_cyc = 0;

	sdram_link_if link ();

	// Free-running 25 MHz clock.
	always #20 clk_i = ~clk_i;

	// Both ends face each other; the checker watches the wire.
	sdram_host_ctrl sdram_host_ctrl_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .link(link));
	sdram_module_dev #(.COLS(1024), .DEPTH(64)) sdram_module_dev_i (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .link(link),
		.open_banks_o(open_banks), .self_refresh_o(self_refresh),
		.auto_pre_o(auto_pre), .refresh_count_o(refresh_count));
	sdram_link_assertions sdram_link_assertions_i (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .cke(link.cke),
		.addr(link.addr), .byte_data_mask(link.byte_data_mask),
		.dq_dev_oe_n(link.dq_dev_oe_n));

	// Records the read cycle and every driven word, sampled mid-cycle
	// where the registered link levels have settled.
	always @(negedge clk_i) begin
		cyc <= cyc + 1;
		if ({link.cs_n, link.ras_n, link.cas_n, link.we_n} === 4'h5)
			rd_cyc = cyc;
		if (link.dq_dev_oe_n === 1'b0) begin
			if (q.size() == 0)
				first_cyc = cyc;
			q.push_back(link.dq);
		end
	end

	task automatic conclude();
		$display("Compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest is seen low.
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int i;
		logic w;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		w = 1'b1;
		for (i = 0; i < 20; i++) begin
			// Answer is registered: the mid-cycle level stands at the edge.
			@(negedge clk_i);
			w = avs_waitrequest;
			rdv = avs_readdata;
			@(posedge clk_i);
			if (w === 1'b0)
				break;
		end
		if (i == 20) begin
			err_total++;
			conclude();
		end
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_i);
	endtask

	// Loads address and bank, then issues one link command.
	task automatic cmd(input logic [3:0] c, input logic [12:0] a,
		input logic [1:0] b, input logic [1:0] f);
		av(1'b1, sdram_cmd_pkg::REG_ADDR, {14'h0, b, 3'h0, a});
		av(1'b1, sdram_cmd_pkg::REG_CMD, {26'h0, f, c});
		repeat (2) @(posedge clk_i);
	endtask

	// Loads a mode, reads one burst and checks order and latency.
	task automatic burst(input logic [12:0] m, input logic [12:0] col);
		int len;
		int k;
		logic [2:0] s;
		if (m[8:7] == 2'h0 && m[6:5] == 2'h1 && !(m[2:0] == 3'h7 && m[3]))
			eff = m;
		cmd(sdram_cmd_pkg::CMD_LMR, m, 2'h0, 2'h0);
		q.delete();
		cmd(sdram_cmd_pkg::CMD_READ, col, 2'h0, 2'h0);
		repeat (16) @(posedge clk_i);
		len = 1 << eff[1:0];
		chk(q.size(), len);
		chk(first_cyc - rd_cyc, eff[6:4] + sdram_cmd_pkg::REG_EXTRA);
		for (k = 0; k < len; k++) begin
			s = 3'((eff[3] ? (col[2:0] ^ k) : (col[2:0] + k)) & (len - 1));
			chk(q[k], 8'(8'hA0 + ((col[2:0] & ~(len - 1)) | s)));
		end
		chk(auto_pre, col[10]);
	endtask

	// Main sequence: fill, burst table, single write, banks, refresh.
	initial begin
		int i;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		cmd(sdram_cmd_pkg::CMD_ACT, 13'h123, 2'h0, 2'h0);
		cmd(sdram_cmd_pkg::CMD_LMR, 13'h020, 2'h0, 2'h0);
		for (i = 0; i < 9; i++) begin
			av(1'b1, sdram_cmd_pkg::REG_DATA, 32'hA0 + i);
			cmd(sdram_cmd_pkg::CMD_WRITE, 13'(i), 2'h0, 2'h0);
		end
		av(1'b1, sdram_cmd_pkg::REG_DATA, 32'h100);
		for (i = 0; i < 9; i++)
			burst(modes[i], cols[i]);
		cmd(sdram_cmd_pkg::CMD_LMR, 13'h027, 2'h0, 2'h0);
		q.delete();
		cmd(sdram_cmd_pkg::CMD_READ, 13'h006, 2'h0, 2'h0);
		cmd(sdram_cmd_pkg::CMD_TERM, 13'h000, 2'h0, 2'h0);
		repeat (8) @(posedge clk_i);
		chk(q.size(), 8);
		chk(q[2], 8'hA8);
		cmd(sdram_cmd_pkg::CMD_ACT, 13'h123, 2'h0, 2'h0);
		cmd(sdram_cmd_pkg::CMD_LMR, 13'h222, 2'h0, 2'h0);
		av(1'b1, sdram_cmd_pkg::REG_DATA, 32'hA4);
		cmd(sdram_cmd_pkg::CMD_WRITE, 13'h004, 2'h0, 2'h0);
		av(1'b1, sdram_cmd_pkg::REG_DATA, 32'h100);
		burst(13'h022, 13'h004);
		q.delete();
		cmd(sdram_cmd_pkg::CMD_READ, 13'h000, 2'h0, 2'h2);
		repeat (16) @(posedge clk_i);
		chk(q.size(), 0);
		cmd(sdram_cmd_pkg::CMD_ACT, 13'h055, 2'h2, 2'h0);
		chk(open_banks, 4'h5);
		av(1'b0, sdram_cmd_pkg::REG_ADDR, 32'h0);
		chk(rdv, 32'h0002_0055);
		cmd(sdram_cmd_pkg::CMD_PRE, 13'h000, 2'h2, 2'h0);
		chk(open_banks, 4'h1);
		cmd(sdram_cmd_pkg::CMD_PRE, 13'h400, 2'h1, 2'h0);
		chk(open_banks, 4'h0);
		cmd(sdram_cmd_pkg::CMD_REF, 13'h000, 2'h0, 2'h0);
		cmd(sdram_cmd_pkg::CMD_REF, 13'h000, 2'h0, 2'h0);
		chk(refresh_count, 8'h02);
		cmd(sdram_cmd_pkg::CMD_REF, 13'h000, 2'h0, 2'h1);
		chk(self_refresh, 1'b1);
		av(1'b0, sdram_cmd_pkg::REG_STATUS, 32'h0);
		chk(rdv[8], 1'b0);
		conclude();
	end
endmodule
